//--- rtl/scr_sensor_config_registers.sv
// Configuration register bank of the inductive touch sensor.
// Assumes a two-wire host on scl and sda and a measurement core around it.
`timescale 1ns/100ps
`include "scr_consts.svh"

module scr_sensor_config_registers
   import scr_pkg::*;
#(
   parameter int unsigned PER80_CYC  = `SCR_PER80_US * `SCR_CLK_MHZ,
   parameter int unsigned PER40_CYC  = `SCR_PER40_US * `SCR_CLK_MHZ,
   parameter int unsigned PER20_CYC  = `SCR_PER20_US * `SCR_CLK_MHZ,
   parameter int unsigned PER10_CYC  = `SCR_PER10_US * `SCR_CLK_MHZ,
   parameter int unsigned PER160_CYC = `SCR_PER160_US * `SCR_CLK_MHZ
)
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic [11:0] chan3_result,
   input  wire logic        chip_ready,
   input  wire logic        lowpower_mode,
   input  wire logic        scan_busy,
   output scr_chan_cfg_s    chan_cfg,
   output logic [5:0]       chan0_sensitivity,
   output logic             device_reset,
   output logic             conversion_run,
   output logic             scan_start,
   output logic             fixed_base_inc
);

   logic        cfg_hold_q;
   logic        wait_ready_q;
   logic        fast_rate_select;
   logic        continuous_scan;
   logic [1:0]  normal_rate_code;
   logic [7:0]  rd_addr;
   logic [7:0]  rd_data;
   logic [23:0] cnt_q;
   logic [23:0] period;
   logic        run;
   scr_wr_s     wr;

   // ****************************************************************
   // Serial port
   // ****************************************************************
   // The line is open drain: only a low level is ever driven.
   scr_i2c_slave u_port (
      .clock   (clock),
      .reset_n (reset_n),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .sda_oe  (sda_oe),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .wr      (wr)
   );

   // Driven value of the data line is constant low.
   always_ff @(posedge clock) begin
      sda_out <= 1'b0;
   end

   // ****************************************************************
   // Device reset request
   // ****************************************************************
   // The request bit is never stored, so it reads back as zero.
   // The serial port is not reset with it, so the write that asked for
   // the reset still ends cleanly on the bus.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         device_reset <= 1'b0;
      end else begin
         device_reset <= wr.valid && wr.addr == `SCR_OFF_RESET_CTRL
                         && wr.data[`SCR_BIT_FULL_RESET];
      end
   end

   // Hold-off after a full reset; a new reset wins over chip ready.
   // A ready level that is already high ends the wait one cycle later.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wait_ready_q <= 1'b0;
      end else if (device_reset) begin
         wait_ready_q <= 1'b1;
      end else if (chip_ready) begin
         wait_ready_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Writable registers
   // ****************************************************************
   // Configuration hold bit; only bit 0 of its register is kept.
   always_ff @(posedge clock) begin
      if (!reset_n || device_reset) begin
         cfg_hold_q <= 1'b0;
      end else if (wr.valid && wr.addr == `SCR_OFF_RESET_CTRL) begin
         cfg_hold_q <= wr.data[`SCR_BIT_CFG_HOLD];
      end
   end

   // Channel enables, one bit each for normal and low-power scanning.
   // Enabling low power without the normal bit is left to the host.
   always_ff @(posedge clock) begin
      if (!reset_n || device_reset) begin
         chan_cfg <= `SCR_RST_CHAN_EN;
      end else if (wr.valid && wr.addr == `SCR_OFF_CHAN_EN) begin
         chan_cfg <= wr.data;
      end
   end

   // Normal power scan rate fields; bits 7 to 4 are not stored.
   always_ff @(posedge clock) begin
      if (!reset_n || device_reset) begin
         fast_rate_select <= 1'b0;
         continuous_scan  <= 1'b0;
         normal_rate_code <= `SCR_RST_RATE_CODE;
      end else if (wr.valid && wr.addr == `SCR_OFF_NP_RATE) begin
         fast_rate_select <= wr.data[`SCR_BIT_FAST];
         continuous_scan  <= wr.data[`SCR_BIT_CONT];
         normal_rate_code <= wr.data[1:0];
      end
   end

   // Channel 0 gain; the two reserved top bits are dropped.
   always_ff @(posedge clock) begin
      if (!reset_n || device_reset) begin
         chan0_sensitivity <= `SCR_RST_GAIN;
      end else if (wr.valid && wr.addr == `SCR_OFF_CH0_GAIN) begin
         chan0_sensitivity <= wr.data[5:0];
      end
   end

   // ****************************************************************
   // Read multiplexer
   // ****************************************************************
   // Unmapped offsets and reserved bits read as zero. The result bytes are
   // taken live, not latched: a host that reads both halves while a new
   // result lands can see a torn value, so it reads under hold or when idle.
   always_comb begin
      rd_data = 8'h00;
      unique case (rd_addr)
         `SCR_OFF_CH3_LOW:    rd_data = chan3_result[7:0];
         `SCR_OFF_CH3_HIGH:   rd_data = {4'h0, chan3_result[11:8]};
         `SCR_OFF_RESET_CTRL: rd_data = {7'h00, cfg_hold_q};
         `SCR_OFF_CHAN_EN:    rd_data = chan_cfg;
         `SCR_OFF_NP_RATE:    rd_data = {4'h0, fast_rate_select, continuous_scan,
                                         normal_rate_code};
         `SCR_OFF_CH0_GAIN:   rd_data = {2'h0, chan0_sensitivity};
         default:             rd_data = 8'h00;
      endcase
   end

   // ****************************************************************
   // Scan scheduling
   // ****************************************************************
   // Conversions run only outside the hold and, following a full reset, after chip ready.
   assign run = !cfg_hold_q && !wait_ready_q && !device_reset;

   // Period priority: fast bit over the rate code. Continuous scanning
   // overrides both in the tick process below and needs no period.
   always_comb begin
      unique case (normal_rate_code)
         2'h0:    period = PER80_CYC[23:0];
         2'h1:    period = PER40_CYC[23:0];
         2'h2:    period = PER20_CYC[23:0];
         default: period = PER10_CYC[23:0];
      endcase
      if (fast_rate_select) begin
         period = PER160_CYC[23:0];
      end
   end

   // Run flag and the fixed base increment flag for the scheduler.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         conversion_run <= 1'b0;
         fixed_base_inc <= 1'b0;
      end else begin
         conversion_run <= run;
         fixed_base_inc <= continuous_scan && !lowpower_mode;
      end
   end

   // Normal power scan tick. Continuous mode starts a scan whenever the
   // core is idle; the pulse gap stops a second start before busy rises.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         cnt_q      <= 24'h000000;
         scan_start <= 1'b0;
      end else if (!run || lowpower_mode) begin
         cnt_q      <= 24'h000000;
         scan_start <= 1'b0;
      end else if (continuous_scan) begin
         cnt_q      <= 24'h000000;
         scan_start <= !scan_busy && !scan_start;
      end else if (cnt_q >= period - 24'h000001) begin
         cnt_q      <= 24'h000000;
         scan_start <= 1'b1;
      end else begin
         cnt_q      <= cnt_q + 24'h000001;
         scan_start <= 1'b0;
      end
   end

endmodule

//--- shared/scr_consts.svh
// Named constants of the sensor configuration register bank.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SCR_OFF_CH3_LOW     8'h08
`define SCR_OFF_CH3_HIGH    8'h09
`define SCR_OFF_RESET_CTRL  8'h0A
`define SCR_OFF_CHAN_EN     8'h0C
`define SCR_OFF_NP_RATE     8'h0D
`define SCR_OFF_CH0_GAIN    8'h0E

// ****************************************************************
// Field positions, reset values and the target address
// ****************************************************************
`define SCR_BIT_FULL_RESET  4
`define SCR_BIT_CFG_HOLD    0
`define SCR_BIT_FAST        3
`define SCR_BIT_CONT        2
`define SCR_RST_CHAN_EN     8'h1F
`define SCR_RST_RATE_CODE   2'h1
`define SCR_RST_GAIN        6'h28
`define SCR_I2C_ADDR        7'h2A

// ****************************************************************
// Scan periods in microseconds, and the clock rate
// ****************************************************************
`define SCR_CLK_MHZ         100
`define SCR_PER80_US        12500
`define SCR_PER40_US        25000
`define SCR_PER20_US        50000
`define SCR_PER10_US        100000
`define SCR_PER160_US       6250

`endif

//--- shared/scr_pkg.sv
// Types shared by the register bank and its serial port.
// Assumes the constants header lies on the include path.
package scr_pkg;

   // Register write request from the serial port, valid for one cycle.
   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
      logic [7:0] data;
   } scr_wr_s;

   // Channel enables for normal and low-power scanning.
   typedef struct packed {
      logic [3:0] lowpower_on;
      logic [3:0] chan_on;
   } scr_chan_cfg_s;

   // Serial port protocol states.
   typedef enum logic [2:0] {
      SCR_IDLE,
      SCR_RX,
      SCR_ACK,
      SCR_TX,
      SCR_RACK
   } scr_i2c_state_e;

endpackage

//--- rtl/scr_i2c_slave.sv
// Two-wire serial target port: address, register pointer, data bytes.
// Assumes scl and sda inputs are synchronous to clock and slow against it.
`timescale 1ns/100ps
`include "scr_consts.svh"

module scr_i2c_slave
   import scr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_oe,
   output logic [7:0]      rd_addr,
   input  wire logic [7:0] rd_data,
   output scr_wr_s         wr
);

   logic           scl_q, sda_q;
   logic [2:0]     bit_q;
   logic [1:0]     phase_q;
   logic           rw_q;
   logic [7:0]     sh_q;
   scr_i2c_state_e st_q;
   logic           rise, fall, start, stop;
   logic [7:0]     byte_in;

   // ****************************************************************
   // Line event detection
   // ****************************************************************
   // Start and stop are data edges while the clock line stays high.
   assign rise    = scl_in & ~scl_q;
   assign fall    = ~scl_in & scl_q;
   assign start   = scl_in & scl_q & sda_q & ~sda_in;
   assign stop    = scl_in & scl_q & ~sda_q & sda_in;
   assign byte_in = {sh_q[6:0], sda_in};

   // Previous line levels for edge detection.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // ****************************************************************
   // Protocol engine
   // ****************************************************************
   // The pointer advances after every data byte so bursts walk the map.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         st_q    <= SCR_IDLE;
         bit_q   <= 3'h0;
         phase_q <= 2'h0;
         rw_q    <= 1'b0;
         sh_q    <= 8'h00;
         sda_oe  <= 1'b0;
         rd_addr <= 8'h00;
         wr      <= '0;
      end else begin
         wr.valid <= 1'b0;
         if (start) begin
            st_q    <= SCR_RX;
            bit_q   <= 3'h0;
            phase_q <= 2'h0;
            sda_oe  <= 1'b0;
         end else if (stop) begin
            st_q   <= SCR_IDLE;
            sda_oe <= 1'b0;
         end else begin
            unique case (st_q)
               SCR_IDLE: ;
               SCR_RX: if (rise) begin
                  sh_q  <= byte_in;
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     st_q <= SCR_ACK;
                     if (phase_q == 2'h0) begin
                        rw_q <= byte_in[0];
                        if (byte_in[7:1] != `SCR_I2C_ADDR) st_q <= SCR_IDLE;
                     end else if (phase_q == 2'h1) begin
                        rd_addr <= byte_in;
                     end else begin
                        wr.valid <= 1'b1;
                        wr.addr  <= rd_addr;
                        wr.data  <= byte_in;
                        rd_addr  <= rd_addr + 8'h01;
                     end
                  end
               end
               SCR_ACK: if (fall) begin
                  sda_oe <= ~sda_oe;
                  bit_q  <= 3'h0;
                  if (sda_oe) begin
                     if (phase_q != 2'h2) phase_q <= phase_q + 2'h1;
                     if (rw_q) begin
                        st_q    <= SCR_TX;
                        sh_q    <= rd_data;
                        sda_oe  <= ~rd_data[7];
                        rd_addr <= rd_addr + 8'h01;
                     end else begin
                        st_q <= SCR_RX;
                     end
                  end
               end
               SCR_TX: if (fall) begin
                  bit_q  <= bit_q + 3'h1;
                  sh_q   <= {sh_q[6:0], 1'b0};
                  sda_oe <= (bit_q == 3'h7) ? 1'b0 : ~sh_q[6];
                  if (bit_q == 3'h7) st_q <= SCR_RACK;
               end
               SCR_RACK: if (rise) begin
                  // A not-acknowledge ends the read burst. The line is only taken
                  // again when the host already holds it low, so no level change
                  // while the clock is high can look like a start or a stop.
                  st_q   <= sda_in ? SCR_IDLE : SCR_ACK;
                  sda_oe <= ~sda_in;
               end
               default: st_q <= SCR_IDLE;
            endcase
         end
      end
   end

endmodule

//--- verification/scr_sensor_config_registers_props.sv
// Checker for the outputs of the sensor configuration register bank.
// Assumes it is bound to the bank and watches its ports only.
`timescale 1ns/100ps

module scr_sensor_config_registers_props
   import scr_pkg::*;
(
   input wire logic          clock,
   input wire logic          reset_n,
   input wire logic          chip_ready,
   input wire logic          lowpower_mode,
   input wire logic          scan_busy,
   input wire scr_chan_cfg_s chan_cfg,
   input wire logic [5:0]    chan0_sensitivity,
   input wire logic          device_reset,
   input wire logic          conversion_run,
   input wire logic          scan_start,
   input wire logic          fixed_base_inc
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   // One clock domain, so clocking and the reset mask are declared once.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   rst_values_a : assert property (
      $rose(reset_n) |-> chan_cfg == 8'h1F && chan0_sensitivity == 6'h28 && !device_reset)
      else $error("Register image wrong after reset release.");
   // The registers take their defaults at the edge that samples the pulse.
   soft_defaults_a : assert property (
      device_reset |=> chan_cfg == 8'h1F && chan0_sensitivity == 6'h28)
      else $error("Soft reset left registers off their defaults.");
   reset_pulse_a : assert property (
      device_reset |=> !device_reset)
      else $error("Device reset pulse longer than one cycle.");
   ready_wait_a : assert property (
      device_reset && !chip_ready ##1 !chip_ready [*2] |-> !conversion_run)
      else $error("Conversions resumed before chip ready.");
   hold_quiet_a : assert property (
      !conversion_run [*2] |-> !scan_start)
      else $error("Scan started while conversions are stopped.");
   start_single_a : assert property (
      scan_start |=> !scan_start)
      else $error("Two scan starts in adjacent cycles.");
   lowpower_quiet_a : assert property (
      lowpower_mode [*2] |-> !scan_start && !fixed_base_inc)
      else $error("Normal scanning active in low power mode.");
   busy_hold_a : assert property (
      fixed_base_inc && $past(fixed_base_inc) && $past(scan_busy) |-> !scan_start)
      else $error("Continuous scan started while the core was busy.");
   cont_prompt_a : assert property (
      (fixed_base_inc && conversion_run && !scan_busy) [*4]
         |-> scan_start || $past(scan_start) || $past(scan_start, 2))
      else $error("Continuous scan left the core idle.");
endmodule

bind scr_sensor_config_registers scr_sensor_config_registers_props u_props (
   .clock(clock), .reset_n(reset_n), .chip_ready(chip_ready),
   .lowpower_mode(lowpower_mode), .scan_busy(scan_busy), .chan_cfg(chan_cfg),
   .chan0_sensitivity(chan0_sensitivity), .device_reset(device_reset),
   .conversion_run(conversion_run), .scan_start(scan_start),
   .fixed_base_inc(fixed_base_inc));

//--- verification/scr_host_model.sv
// Host controller model for the two-wire register port.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/100ps

module scr_host_model #(
   parameter int HALF = 4
)
(
   input  wire logic clock,
   output logic      scl,
   output logic      sda,
   input  wire logic sda_line
);
   // ****************************************************************
   // Bus primitives
   // ****************************************************************
   // Both lines rest released; the clock line stands still between frames.
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   // Whole cycles only, so every line change lands just after an edge.
   task automatic pause(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Data changes only while the clock line is low, so no false start appears.
   task automatic clk_bit(input logic b, output logic r);
      pause(HALF);
      sda <= b;
      pause(HALF);
      scl <= 1'b1;
      pause(HALF);
      r = sda_line;
      scl <= 1'b0;
   endtask

   task automatic start();
      pause(HALF);
      sda <= 1'b1;
      pause(HALF);
      scl <= 1'b1;
      pause(HALF);
      sda <= 1'b0;
      pause(HALF);
      scl <= 1'b0;
   endtask

   task automatic stop();
      pause(HALF);
      sda <= 1'b0;
      pause(HALF);
      scl <= 1'b1;
      pause(HALF);
      sda <= 1'b1;
      pause(HALF);
   endtask

   // Bytes go most significant bit first; the ninth bit is the target's answer.
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
      clk_bit(1'b1, r);
      ack = ~r;
   endtask

   // Only single-byte reads are made, so every byte ends with a refusal.
   task automatic get_byte(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, r);
         d[i] = r;
      end
      clk_bit(1'b1, r);
   endtask

   // ****************************************************************
   // Register transfers
   // ****************************************************************
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] off, dat,
                            output logic ack);
      logic a0, a1, a2;
      start();
      put_byte({dev, 1'b0}, a0);
      put_byte(off, a1);
      put_byte(dat, a2);
      stop();
      ack = a0 & a1 & a2;
   endtask

   task automatic read_reg(input logic [6:0] dev, input logic [7:0] off,
                           output logic [7:0] dat, output logic ack);
      logic a0, a1, a2;
      start();
      put_byte({dev, 1'b0}, a0);
      put_byte(off, a1);
      start();
      put_byte({dev, 1'b1}, a2);
      get_byte(dat);
      stop();
      ack = a0 & a1 & a2;
   endtask
endmodule

//--- verification/tb_sensor_config_registers.sv
// Self-checking bench for the sensor configuration register bank.
// Assumes the host model, the bound checker and shortened scan periods.
`timescale 1ns/100ps
`include "scr_consts.svh"

module tb_sensor_config_registers
   import scr_pkg::*;
;
   localparam int P80 = 16, P40 = 20, P20 = 24, P10 = 28, P160 = 8;
   localparam logic [7:0] RATE [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0B, 8'h0F};
   localparam logic [7:0] GAPS [6] = '{8'(P80), 8'(P40), 8'(P20), 8'(P10), 8'(P160), 8'h02};
   logic          clock, reset_n, chip_ready, lowpower_mode, scan_busy, scl, host_sda;
   logic          sda_out, sda_oe, device_reset, conversion_run, scan_start, fixed_base_inc;
   logic [11:0]   chan3_result;
   logic [5:0]    chan0_sensitivity;
   logic [7:0]    n;
   logic          nak;
   scr_chan_cfg_s chan_cfg;
   int            errors, checked, resets_seen;
   wire           sda_line = host_sda & (sda_oe ? sda_out : 1'b1);

   scr_sensor_config_registers #(.PER80_CYC(P80), .PER40_CYC(P40), .PER20_CYC(P20),
      .PER10_CYC(P10), .PER160_CYC(P160)) u_dut (.clock(clock), .reset_n(reset_n),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .chan3_result(chan3_result), .chip_ready(chip_ready), .lowpower_mode(lowpower_mode),
      .scan_busy(scan_busy), .chan_cfg(chan_cfg), .chan0_sensitivity(chan0_sensitivity),
      .device_reset(device_reset), .conversion_run(conversion_run),
      .scan_start(scan_start), .fixed_base_inc(fixed_base_inc));
   scr_host_model u_host (.clock(clock), .scl(scl), .sda(host_sda), .sda_line(sda_line));

   // ****************************************************************
   // Clock, pulse count and watchdog
   // ****************************************************************
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Counts soft reset pulses, since no task is awake when one appears.
   always @(posedge clock) if (device_reset === 1'b1) resets_seen <= resets_seen + 1;

   // The whole run needs some 18,000 cycles; a hang is cut well after that.
   initial begin
      #700_000;
      errors++;
      final_report();
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input logic [7:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] off, dat);
      logic a;
      u_host.write_reg(`SCR_I2C_ADDR, off, dat, a);
      check({7'h0, a}, 8'h01);
   endtask

   task automatic rd(input logic [7:0] off, exp);
      logic [7:0] d;
      logic       a;
      u_host.read_reg(`SCR_I2C_ADDR, off, d, a);
      check({7'h0, a}, 8'h01);
      check(d, exp);
   endtask

   // Gap between two scan starts; 200 stands for none seen.
   task automatic gap(output logic [7:0] g);
      g = 8'h00;
      repeat (200) begin
         @(posedge clock);
         if (scan_start === 1'b1) break;
      end
      repeat (200) begin
         @(posedge clock);
         g++;
         if (scan_start === 1'b1) break;
      end
   endtask

   task automatic defaults();
      rd(8'h0A, 8'h00);
      rd(8'h0C, 8'h1F);
      rd(8'h0D, 8'h01);
      rd(8'h0E, 8'h28);
      check(chan_cfg, 8'h1F);
      check({2'h0, chan0_sensitivity}, 8'h28);
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      reset_n = 1'b0;
      chip_ready = 1'b1;
      lowpower_mode = 1'b0;
      scan_busy = 1'b0;
      chan3_result = 12'hA5C;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      repeat (2) @(posedge clock);
      defaults();
      rd(8'h08, 8'h5C);
      rd(8'h09, 8'h0A);
      wr(8'h08, 8'hAA);
      rd(8'h08, 8'h5C);
      chan3_result <= 12'h7F3;
      rd(8'h09, 8'h07);
      rd(8'h0B, 8'h00);
      // Configuration is changed under hold, as the host is expected to do.
      wr(8'h0A, 8'hEF);
      rd(8'h0A, 8'h01);
      check({7'h0, conversion_run}, 8'h00);
      gap(n);
      check(n, 8'hC8);
      wr(8'h0E, 8'hFF);
      rd(8'h0E, 8'h3F);
      check({2'h0, chan0_sensitivity}, 8'h3F);
      // A frame for another target address is refused and changes nothing.
      u_host.write_reg(7'h15, 8'h0E, 8'h00, nak);
      check({7'h0, nak}, 8'h00);
      rd(8'h0E, 8'h3F);
      wr(8'h0C, 8'h37);
      check(chan_cfg, 8'h37);
      // Each rate is set under hold so the period counter starts afresh.
      for (int i = 0; i < 6; i++) begin
         wr(8'h0A, 8'h01);
         wr(8'h0D, RATE[i]);
         wr(8'h0A, 8'h00);
         gap(n);
         gap(n);
         check(n, GAPS[i]);
      end
      rd(8'h0D, 8'h0F);
      check({7'h0, fixed_base_inc}, 8'h01);
      scan_busy <= 1'b1;
      gap(n);
      check(n, 8'hC8);
      scan_busy <= 1'b0;
      lowpower_mode <= 1'b1;
      repeat (3) @(posedge clock);
      check({7'h0, fixed_base_inc}, 8'h00);
      gap(n);
      check(n, 8'hC8);
      lowpower_mode <= 1'b0;
      chip_ready <= 1'b0;
      wr(8'h0A, 8'h10);
      check({7'h0, conversion_run}, 8'h00);
      defaults();
      check({7'h0, conversion_run}, 8'h00);
      chip_ready <= 1'b1;
      repeat (3) @(posedge clock);
      check({7'h0, conversion_run}, 8'h01);
      check(resets_seen[7:0], 8'h01);
      final_report();
   end
endmodule
